// file: bench/bcp_host.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// host processor model on ahb-lite
// ---------------------------------------------------------------
module bcp_host (
  // clock
  input wire logic clk,
  // master side of the bus
  output logic hsel,
  output logic [15:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  // idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 16'h0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
  end

  // one single word transfer; every read gets its own address phase
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata;
    hwdata <= ~d; // released data must not look valid
  endtask
endmodule

// file: bench/bcp_top_tb.sv
`timescale 1ns/100ps
`include "bcp_defines.svh"
module bcp_top_tb;
  import bcp_pkg::*;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic clk, rst_n, pwr_good, batt_below, day_roll, year_roll;
  logic hsel, hwrite, hready, hresp, irq, batt_low, century;
  logic [15:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  int num_errors = 0;
  int checks = 0;

  bcp_top bcp_top_i (.CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready),
    .HRDATA(hrdata), .HRESP(hresp), .PWR_GOOD(pwr_good), .BATT_BELOW(batt_below),
    .DAY_ROLL(day_roll), .YEAR_ROLL(year_roll), .IRQ(irq), .BATT_LOW(batt_low), .CENTURY(century));

  bcp_host bcp_host_i (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (num_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    bcp_host_i.xfer(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bcp_host_i.xfer(1'b0, a, 32'h00000000, q);
    chk(q, exp);
  endtask

  // waits n edges, then lands at a falling edge for pin checks
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // rising edge on the day or year rollover pin
  task automatic pulse(input logic yr);
    @(posedge clk);
    if (yr) begin
      year_roll <= 1'b1;
    end else begin
      day_roll <= 1'b1;
    end
    repeat (3) @(posedge clk);
    year_roll <= 1'b0;
    day_roll <= 1'b0;
    wt(4);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_defaults();
    rdc(`BCP_ADDR_LATCH, 32'h00000000);
    chk(hready, 32'h1);
    chk(hresp, 32'h0);
    rdc(`BCP_ADDR_ALARM, 32'h00000000);
    rdc(`BCP_ADDR_WDOG, 32'h00000000);
    wr(16'h1F00, 32'h000000FF);
    rdc(16'h1F00, 32'h00000000);
    rdc(`BCP_ADDR_FLAGS, 32'h00000000);
  endtask

  task automatic t_battery();
    wr(`BCP_ADDR_MASK, 32'h00000000);
    batt_below <= 1'b1;
    pulse(1'b0);
    chk(batt_low, 32'h1);
    chk(irq, 32'h0);
    rdc(`BCP_ADDR_FLAGS, 32'h00000010);
    rdc(`BCP_ADDR_STAT, 32'h00000001);
    wr(`BCP_ADDR_MASK, 32'h00000001);
    wt(2);
    chk(irq, 32'h1);
    wr(`BCP_ADDR_STAT, 32'h00000001);
    batt_below <= 1'b0;
    wt(5);
    chk(irq, 32'h0);
    chk(batt_low, 32'h1);
    pulse(1'b0);
    chk(batt_low, 32'h0);
  endtask

  task automatic t_power();
    wr(`BCP_ADDR_LATCH, 32'h00000080);
    wr(`BCP_ADDR_ALARM, 32'h000000A0);
    wr(`BCP_ADDR_WDOG, 32'h0000008E);
    wr(`BCP_ADDR_CLOCK, 32'h00000045);
    pwr_good <= 1'b0;
    batt_below <= 1'b1;
    wt(6);
    rdc(`BCP_ADDR_LATCH, 32'h00000000);
    rdc(`BCP_ADDR_WDOG, 32'h00000000);
    rdc(`BCP_ADDR_ALARM, 32'h000000A0);
    rdc(`BCP_ADDR_CLOCK, 32'h00000005);
    rdc(`BCP_ADDR_STAT, 32'h00000004);
    pulse(1'b0);
    chk(batt_low, 32'h0);
    @(posedge clk);
    pwr_good <= 1'b1;
    wt(6);
    chk(batt_low, 32'h1);
    rdc(`BCP_ADDR_ALARM, 32'h00000000);
    rdc(`BCP_ADDR_CLOCK, 32'h00000005);
    batt_below <= 1'b0;
  endtask

  task automatic t_century();
    wr(`BCP_ADDR_CLOCK, 32'h00000030);
    rdc(`BCP_ADDR_CLOCK, 32'h00000020);
    wr(`BCP_ADDR_LATCH, 32'h00000080);
    wr(`BCP_ADDR_CLOCK, 32'h00000030);
    rdc(`BCP_ADDR_CLOCK, 32'h00000030);
    wr(`BCP_ADDR_CLOCK, 32'h00000020);
    wr(`BCP_ADDR_LATCH, 32'h00000000);
    wr(`BCP_ADDR_YEAR, 32'h00000063);
    pulse(1'b1);
    chk(century, 32'h1);
    rdc(`BCP_ADDR_YEAR, 32'h00000000);
    wr(`BCP_ADDR_YEAR, 32'h00000062);
    pulse(1'b1);
    chk(century, 32'h1);
    rdc(`BCP_ADDR_YEAR, 32'h00000063);
    wr(`BCP_ADDR_CLOCK, 32'h00000000);
    pulse(1'b1);
    chk(century, 32'h1);
    rdc(`BCP_ADDR_CLOCK, 32'h00000010);
  endtask

  // ---------------------------------------------------------------
  // clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // cuts a hang short
  initial begin
    #100000;
    num_errors++;
    results();
  end

  // reset, then the scenarios in order
  initial begin
    rst_n = 1'b0;
    pwr_good = 1'b1;
    batt_below = 1'b0;
    day_roll = 1'b0;
    year_roll = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    t_defaults();
    t_battery();
    t_power();
    t_century();
    results();
  end
endmodule

// file: hdl/bcp_defines.svh
`ifndef BCP_DEFINES_SVH
`define BCP_DEFINES_SVH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define BCP_ADDR_FLAGS 16'h1FF0
`define BCP_ADDR_CLOCK 16'h1FFC
`define BCP_ADDR_LATCH 16'h1FE0
`define BCP_ADDR_ALARM 16'h1FE4
`define BCP_ADDR_WDOG 16'h1FE8
`define BCP_ADDR_YEAR 16'h1FEC
`define BCP_ADDR_STAT 16'h1FD8
`define BCP_ADDR_MASK 16'h1FDC

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define BCP_BL_BIT 4
`define BCP_FT_BIT 6
`define BCP_CEB_BIT 5
`define BCP_CB_BIT 4
`define BCP_DOW_MSB 2
`define BCP_WLATCH_BIT 7
`define BCP_RLATCH_BIT 6
`define BCP_AFE_BIT 7
`define BCP_ABE_BIT 5
`define BCP_WD_MSB 7
`define BCP_YEAR_MSB 6
`define BCP_EV_MSB 2
`define BCP_EV_BATT 0
`define BCP_EV_CENT 1
`define BCP_EV_PDN 2

// ---------------------------------------------------------------
// values
// ---------------------------------------------------------------
`define BCP_YEAR_LAST 7'h63
`define BCP_YEAR_FIRST 7'h00
`define BCP_WD_CLEAR 8'h00
`define BCP_RESP_OKAY 1'b0
`define BCP_SYNC_W 4

`endif

// file: hdl/bcp_pkg.sv
package bcp_pkg;
`include "bcp_defines.svh"

  // supply condition seen by the block
  typedef enum logic {
    BCP_BACKUP,
    BCP_POWERED
  } bcp_pwr_t;

  // whole state of the top module
  typedef struct packed {
    logic rdy;
    logic resp;
    logic [31:0] rdata;
    logic wr_pend;
    logic [15:0] wr_addr;
    bcp_pwr_t pwr;
    logic day;
    logic ny;
    logic bl;
    logic ft;
    logic ceb;
    logic cb;
    logic [`BCP_DOW_MSB:0] dow;
    logic wlatch;
    logic rlatch;
    logic afe;
    logic abe;
    logic [`BCP_WD_MSB:0] wd;
    logic [`BCP_YEAR_MSB:0] year;
    logic [`BCP_EV_MSB:0] sts;
    logic [`BCP_EV_MSB:0] msk;
    logic irq;
  } bcp_state_t;

endpackage

// file: hdl/bcp_sync.sv
`timescale 1ns/100ps
module bcp_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  // two flip-flops; only the second stage is read outside
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// file: hdl/bcp_top.sv
`timescale 1ns/100ps
`include "bcp_defines.svh"
module bcp_top
  import bcp_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [15:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  // supply and timekeeping pins
  input wire logic PWR_GOOD,
  input wire logic BATT_BELOW,
  input wire logic DAY_ROLL,
  input wire logic YEAR_ROLL,
  // status outputs
  output logic IRQ,
  output logic BATT_LOW,
  output logic CENTURY
);
  import bcp_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [`BCP_SYNC_W-1:0] pins_s;
  logic pg_s;
  logic batt_s;
  logic day_s;
  logic ny_s;

  bcp_sync #(.WIDTH(`BCP_SYNC_W)) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .d({YEAR_ROLL, DAY_ROLL, BATT_BELOW, PWR_GOOD}),
    .q(pins_s)
  );

  // split synchronised pins
  assign pg_s = pins_s[0];
  assign batt_s = pins_s[1];
  assign day_s = pins_s[2];
  assign ny_s = pins_s[3];

  // ---------------------------------------------------------------
  // events
  // ---------------------------------------------------------------
  bcp_state_t s_q;
  bcp_state_t s_d;
  logic pwr_up;
  logic pwr_dn;
  logic day_ev;
  logic ny_ev;
  logic test_ev;
  logic wr_ok;
  logic wr_clk;
  logic acc;

  // supply edges, rollover edges and battery test trigger
  assign pwr_up = (s_q.pwr == BCP_BACKUP) && pg_s;
  assign pwr_dn = (s_q.pwr == BCP_POWERED) && !pg_s;
  assign day_ev = day_s && !s_q.day;
  assign ny_ev = ny_s && !s_q.ny;
  assign test_ev = pwr_up || (day_ev && (s_q.pwr == BCP_POWERED) && pg_s);
  // writes only land while main power is good
  assign wr_ok = s_q.wr_pend && (s_q.pwr == BCP_POWERED) && pg_s;
  assign wr_clk = wr_ok && (s_q.wr_addr == `BCP_ADDR_CLOCK);
  assign acc = HSEL && HTRANS[1] && HREADY;

  // ---------------------------------------------------------------
  // register read mux
  // ---------------------------------------------------------------
  function automatic logic [31:0] bcp_read(input bcp_state_t st, input logic [15:0] a);
    logic [31:0] r;
    r = '0;
    case ({a[15:2], 2'b00})
      `BCP_ADDR_FLAGS: r[`BCP_BL_BIT] = st.bl;
      `BCP_ADDR_CLOCK: begin
        r[`BCP_FT_BIT] = st.ft;
        r[`BCP_CEB_BIT] = st.ceb;
        r[`BCP_CB_BIT] = st.cb;
        r[`BCP_DOW_MSB:0] = st.dow;
      end
      `BCP_ADDR_LATCH: begin
        r[`BCP_WLATCH_BIT] = st.wlatch;
        r[`BCP_RLATCH_BIT] = st.rlatch;
      end
      `BCP_ADDR_ALARM: begin
        r[`BCP_AFE_BIT] = st.afe;
        r[`BCP_ABE_BIT] = st.abe;
      end
      `BCP_ADDR_WDOG: r[`BCP_WD_MSB:0] = st.wd;
      `BCP_ADDR_YEAR: r[`BCP_YEAR_MSB:0] = st.year;
      `BCP_ADDR_STAT: r[`BCP_EV_MSB:0] = st.sts;
      `BCP_ADDR_MASK: r[`BCP_EV_MSB:0] = st.msk;
      default: r = '0; // unmapped reads zero
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [`BCP_EV_MSB:0] ev;
    ev = '0;
    s_d = s_q;
    s_d.day = day_s;
    s_d.ny = ny_s;
    s_d.rdy = 1'b1;
    s_d.resp = `BCP_RESP_OKAY;

    // supply state machine with default values
    unique case (s_q.pwr)
      BCP_BACKUP: begin
        if (pg_s) begin
          s_d.pwr = BCP_POWERED;
          s_d.wlatch = 1'b0;
          s_d.rlatch = 1'b0;
          s_d.ft = 1'b0;
          s_d.afe = 1'b0;
          s_d.abe = 1'b0;
          s_d.wd = `BCP_WD_CLEAR;
        end
      end
      BCP_POWERED: begin
        if (!pg_s) begin
          s_d.pwr = BCP_BACKUP;
          s_d.wlatch = 1'b0;
          s_d.rlatch = 1'b0;
          s_d.ft = 1'b0;
          s_d.wd = `BCP_WD_CLEAR;
          ev[`BCP_EV_PDN] = 1'b1;
        end
      end
    endcase

    // battery test result replaces the flag
    if (test_ev) begin
      s_d.bl = batt_s;
      ev[`BCP_EV_BATT] = batt_s;
    end

    // register writes in the data phase
    if (wr_ok) begin
      case ({s_q.wr_addr[15:2], 2'b00})
        `BCP_ADDR_CLOCK: begin
          s_d.ft = HWDATA[`BCP_FT_BIT];
          s_d.ceb = HWDATA[`BCP_CEB_BIT];
          s_d.dow = HWDATA[`BCP_DOW_MSB:0];
          if (s_q.wlatch) begin
            s_d.cb = HWDATA[`BCP_CB_BIT];
          end
        end
        `BCP_ADDR_LATCH: begin
          s_d.wlatch = HWDATA[`BCP_WLATCH_BIT];
          s_d.rlatch = HWDATA[`BCP_RLATCH_BIT];
        end
        `BCP_ADDR_ALARM: begin
          s_d.afe = HWDATA[`BCP_AFE_BIT];
          s_d.abe = HWDATA[`BCP_ABE_BIT];
        end
        `BCP_ADDR_WDOG: s_d.wd = HWDATA[`BCP_WD_MSB:0];
        `BCP_ADDR_YEAR: s_d.year = HWDATA[`BCP_YEAR_MSB:0];
        `BCP_ADDR_STAT: s_d.sts = s_q.sts & ~HWDATA[`BCP_EV_MSB:0];
        `BCP_ADDR_MASK: s_d.msk = HWDATA[`BCP_EV_MSB:0];
        default: s_d.sts = s_d.sts; // unmapped writes ignored
      endcase
    end

    // year advance; century turn is the wrap to zero
    if (ny_ev) begin
      if (s_q.year == `BCP_YEAR_LAST) begin
        s_d.year = `BCP_YEAR_FIRST;
        if (s_q.ceb) begin
          s_d.cb = ~s_q.cb;
          ev[`BCP_EV_CENT] = 1'b1;
        end else begin
          s_d.cb = s_q.cb;
        end
      end else begin
        s_d.year = s_q.year + 7'h01;
      end
    end

    // sticky status: a new event wins over a clear
    s_d.sts = s_d.sts | ev;

    // address phase: capture writes, prepare read data
    s_d.wr_pend = acc && HWRITE;
    if (acc) begin
      s_d.wr_addr = HADDR;
    end
    if (acc && !HWRITE) begin
      s_d.rdata = bcp_read(s_d, HADDR); // read sees a write still in flight
    end

    // level interrupt
    s_d.irq = |(s_d.sts & s_d.msk);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '0;
      s_q.rdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops
  assign HREADYOUT = s_q.rdy;
  assign HRDATA = s_q.rdata;
  assign HRESP = s_q.resp;
  assign IRQ = s_q.irq;
  assign BATT_LOW = s_q.bl;
  assign CENTURY = s_q.cb;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb_clk @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // test result appears on the flag one cycle later
  bl_update_a: assert property (test_ev |=> BATT_LOW == $past(batt_s))
    else $error("battery flag not updated by test");

  // flag holds between tests
  bl_hold_a: assert property (!test_ev |=> $stable(BATT_LOW))
    else $error("battery flag moved without a test");

  // daily test only while powered
  no_backup_test_a: assert property ((s_q.pwr == BCP_BACKUP && !pg_s) |-> !test_ev)
    else $error("battery test while on backup");

  // century flips at year wrap when enabled
  cent_flip_a: assert property ((ny_ev && s_q.year == `BCP_YEAR_LAST && s_q.ceb)
    |=> CENTURY != $past(CENTURY) && s_q.year == `BCP_YEAR_FIRST)
    else $error("century indicator did not flip");

  // century holds when disabled
  cent_hold_a: assert property ((ny_ev && !s_q.ceb && !wr_clk) |=> $stable(CENTURY))
    else $error("century indicator changed while disabled");

  // century write blocked without latch
  cent_lock_a: assert property ((wr_clk && !s_q.wlatch && !ny_ev) |=> $stable(CENTURY))
    else $error("century written without latch");

  // backup state keeps cleared bits
  backup_clear_a: assert property ((s_q.pwr == BCP_BACKUP)
    |-> (s_q.wd == `BCP_WD_CLEAR && !s_q.wlatch && !s_q.ft))
    else $error("control bits set while on backup");

  // power-up clears all defaults
  pwrup_clr_a: assert property (pwr_up |=> (s_q.wd == `BCP_WD_CLEAR && !s_q.ft && !s_q.afe
    && !s_q.abe && !s_q.wlatch && !s_q.rlatch) [*2])
    else $error("power-up defaults not applied");

  // power-down keeps alarm enables
  pwrdn_keep_a: assert property (pwr_dn |=> s_q.afe == $past(s_q.afe) && s_q.abe == $past(s_q.abe)
    && s_q.wd == `BCP_WD_CLEAR && !s_q.ft && !s_q.wlatch)
    else $error("power-down defaults wrong");

  // ---------------------------------------------------------------
  // bus, status and year assertions
  // ---------------------------------------------------------------

  // zero wait states and an okay response at all times
  bus_okay_a: assert property (HREADYOUT && HRESP == `BCP_RESP_OKAY)
    else $error("bus answer not ready or not okay");

  // interrupt level matches the masked status held in the state
  irq_level_a: assert property (IRQ == |(s_q.sts & s_q.msk))
    else $error("interrupt level does not match masked status");

  // battery status bit only drops through a write to the status register
  sts_sticky_a: assert property ((s_q.sts[`BCP_EV_BATT] && !(wr_ok && s_q.wr_addr == `BCP_ADDR_STAT))
    |=> s_q.sts[`BCP_EV_BATT])
    else $error("status bit cleared without a write");

  // a write pending while on backup leaves the watchdog register alone
  wr_block_a: assert property ((s_q.wr_pend && s_q.pwr == BCP_BACKUP) |=> $stable(s_q.wd))
    else $error("register written while on backup");

  // year counts up by one below the century turn
  year_step_a: assert property ((ny_ev && s_q.year != `BCP_YEAR_LAST && !wr_ok)
    |=> s_q.year == $past(s_q.year) + 7'h01)
    else $error("year counter did not advance");

  // the power-up test also runs when the battery is already low
  pwrup_test_a: assert property ((pwr_up && batt_s) |=> BATT_LOW)
    else $error("power-up battery test missed");

  // scenarios
  low_batt_c: cover property (test_ev && batt_s ##1 BATT_LOW);
  cent_turn_c: cover property (ny_ev && s_q.ceb && s_q.year == `BCP_YEAR_LAST);
  pwrdn_alarm_c: cover property (pwr_dn && s_q.afe);
  cent_keep_c: cover property (ny_ev && !s_q.ceb && s_q.year == `BCP_YEAR_LAST);
  pwrup_low_c: cover property (pwr_up && batt_s);
endmodule
